// *** core/rsase_pkg.sv ***
// Shared constants and types for the rotate/store/accumulator-shift execution block.
// Assumes a 32-bit APB bus with byte addresses and one register per aligned word.
package rsase_pkg;

  // ==========================================================================
  // Datapath widths
  localparam int unsigned ACC_W  = 40;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned INSN_W = 24;
  localparam int unsigned EXT_W  = 56;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_OPERAND  = 8'h08;
  localparam logic [7:0] ADDR_INSN     = 8'h0c;
  localparam logic [7:0] ADDR_ACCA_LO  = 8'h10;
  localparam logic [7:0] ADDR_ACCA_HI  = 8'h14;
  localparam logic [7:0] ADDR_ACCB_LO  = 8'h18;
  localparam logic [7:0] ADDR_ACCB_HI  = 8'h1c;
  localparam logic [7:0] ADDR_RESULT   = 8'h20;
  localparam logic [7:0] ADDR_DEST     = 8'h24;
  localparam logic [7:0] ADDR_SRC      = 8'h28;

  // ==========================================================================
  // Core control register bits
  localparam int unsigned CTRL_ROUND_SEL = 1;
  localparam int unsigned CTRL_WR_CLIP   = 5;
  localparam int unsigned CTRL_B_CLIP    = 6;
  localparam int unsigned CTRL_A_CLIP    = 7;
  localparam logic [7:0]  CTRL_MASK      = 8'he2;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // ==========================================================================
  // Status register bits
  localparam int unsigned ST_C       = 0;
  localparam int unsigned ST_Z       = 1;
  localparam int unsigned ST_N       = 3;
  localparam int unsigned ST_SAB     = 10;
  localparam int unsigned ST_OAB     = 11;
  localparam int unsigned ST_SB      = 12;
  localparam int unsigned ST_SA      = 13;
  localparam int unsigned ST_OB      = 14;
  localparam int unsigned ST_OA      = 15;
  localparam int unsigned ST_TRAP    = 16;
  localparam int unsigned ST_ILLEGAL = 17;
  localparam logic [17:0] ST_RESET   = 18'h00000;

  // ==========================================================================
  // Opcode prefixes (instruction bits 23:16)
  localparam logic [7:0] OPC_ROT_REG   = 8'hd3;
  localparam logic [7:0] OPC_ROT_FILE  = 8'hd7;
  localparam logic [7:0] OPC_STORE_T   = 8'hcc;
  localparam logic [7:0] OPC_STORE_R   = 8'hcd;
  localparam logic [7:0] OPC_WIDEN     = 8'hfb;
  localparam logic [7:0] OPC_FILL_FILE = 8'hef;
  localparam logic [7:0] OPC_FILL_REG  = 8'heb;
  localparam logic [7:0] OPC_ASHIFT    = 8'hc8;

  // Field positions inside the instruction word
  localparam int unsigned F_WIDTH   = 14;
  localparam int unsigned F_ACC     = 15;
  localparam int unsigned F_DSEL    = 13;
  localparam logic [1:0]  ASHIFT_TAG = 2'b01;

  // Shift limits
  localparam logic signed [5:0] SHIFT_MAX = 6'sd16;
  localparam logic signed [5:0] SHIFT_MIN = -6'sd16;

  // Fill, saturation and rounding values
  localparam logic [15:0] FILL_BYTE = 16'h00ff;
  localparam logic [15:0] FILL_WORD = 16'hffff;
  localparam logic [15:0] WORD_POS  = 16'h7fff;
  localparam logic [15:0] WORD_NEG  = 16'h8000;
  localparam logic [39:0] ACC_POS   = 40'h007fffffff;
  localparam logic [39:0] ACC_NEG   = 40'hff80000000;
  localparam logic [39:0] ROUND_INC = 40'h0000010000;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    OP_NONE, OP_ROTATE, OP_STORE_T, OP_STORE_R, OP_WIDEN, OP_FILL, OP_ASHIFT
  } rsase_op_e;

  typedef struct packed {
    logic        written;
    logic        byte_op;
    logic        to_file;
    logic [12:0] file_addr;
    logic [3:0]  offset_reg;
    logic [2:0]  mode;
    logic [3:0]  reg_num;
  } rsase_dest_s;

  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] reg_num;
  } rsase_src_s;

endpackage

// *** core/rsase_acc_shift.sv ***
// Signed 40-bit accumulator shifter with optional 32-bit saturation.
// Assumes a purely combinational use inside one clock cycle.
`timescale 1ns/1ns
module rsase_acc_shift import rsase_pkg::*; (
  input  wire logic [ACC_W-1:0]  acc,
  input  wire logic signed [5:0] amount,
  input  wire logic              clip_en,
  output logic [ACC_W-1:0]       result,
  output logic                   overflow,
  output logic                   clipped
);

  // ==========================================================================
  // Shift in a widened copy so no left-shifted bit is lost before the checks
  logic signed [EXT_W-1:0] ext;
  logic signed [EXT_W-1:0] shifted;
  logic [5:0]              mag;
  logic                    fits32;

  always_comb begin
    ext = EXT_W'($signed(acc));
    mag = amount[5] ? 6'(-amount) : amount;
    if (amount[5]) begin
      shifted = ext <<< mag;
    end else begin
      shifted = ext >>> mag;
    end
    fits32 = (shifted[EXT_W-1:31] == '0) || (shifted[EXT_W-1:31] == '1);
    clipped = clip_en && !fits32;
    if (clipped) begin
      result = shifted[EXT_W-1] ? ACC_NEG : ACC_POS;
    end else begin
      result = shifted[ACC_W-1:0];
    end
    // Overflow means the guard bits 39:31 no longer carry only the sign
    overflow = !((result[ACC_W-1:31] == '0) || (result[ACC_W-1:31] == '1));
  end

endmodule // rsase_acc_shift

// *** core/rsase_core.sv ***
// Execution datapath for rotate, accumulator store, sign-widen, fill and accumulator shift.
// Assumes an APB3 master; source operands are staged by software in the operand register.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns

// What this block does
// - Rotate right without carry, prefix 1101 0011
// - Source LSB to result MSB; only N, Z
// - Width bit 0 word, 1 byte
// - Direct or indirect operand modes from fields
// - Store pre-shift -8..7, write bits 31:16
// - Store keeps accumulator and all flags unchanged
// - 1100 1100 truncates, 1100 1101 rounds
// - Rounding store, conventional or convergent by bit1
// - Control bit 5 saturates stored word
// - Store fields: acc, offset, shift, mode, dest
// - Fill writes 0xff or 0xffff, flags kept
// - File form destination bit: W0 or file 0..8191
// - Default working register is register zero
// - Accumulator 40-bit shift by literal -16..16
// - Accumulator shift updates only overflow/saturation flags, or only the trap flag and the combined OAB/SAB bits when out of range
// - Control bits 7/6 saturate shifted accumulator
// - Accumulator shift prefix 1100 1000, select, literal
// - Out-of-range shift keeps accumulator, raises trap
module rsase_core import rsase_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   arith_trap
);

  // ==========================================================================
  // State
  logic [7:0]        ctrl_q;
  logic [17:0]       status_q;
  logic [WORD_W-1:0] operand_q;
  logic [INSN_W-1:0] insn_q;
  logic [ACC_W-1:0]  acc_a_q;
  logic [ACC_W-1:0]  acc_b_q;
  logic [WORD_W-1:0] result_q;
  rsase_dest_s       dest_q;
  rsase_src_s        src_q;
  logic              trap_q;

  // ==========================================================================
  // APB decode
  logic              access;
  logic              wr_en;
  logic              mapped;
  logic              exec;
  logic [INSN_W-1:0] insn;
  logic [7:0]        addr;

  assign addr = paddr[7:0];

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      ADDR_CTRL, ADDR_STATUS, ADDR_OPERAND, ADDR_INSN, ADDR_ACCA_LO, ADDR_ACCA_HI,
      ADDR_ACCB_LO, ADDR_ACCB_HI, ADDR_RESULT, ADDR_DEST, ADDR_SRC: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign access  = psel && penable;
  assign mapped  = is_mapped(addr);
  assign wr_en   = access && pwrite && mapped;
  assign exec    = wr_en && (addr == ADDR_INSN);
  assign insn    = pwdata[INSN_W-1:0];
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ==========================================================================
  // Instruction decode
  rsase_op_e         op;
  rsase_dest_s       dest;
  rsase_src_s        src;
  logic              acc_sel;
  logic signed [5:0] shift_amt;
  logic              byte_op;

  always_comb begin
    op        = OP_NONE;
    dest      = '0;
    src       = '0;
    acc_sel   = insn[F_ACC];
    shift_amt = '0;
    byte_op   = 1'b0;
    case (insn[23:16])
      OPC_ROT_REG: begin
        op           = OP_ROTATE;
        byte_op      = insn[F_WIDTH];
        dest.mode    = insn[13:11];
        dest.reg_num = insn[10:7];
        src.mode     = insn[6:4];
        src.reg_num  = insn[3:0];
      end
      OPC_ROT_FILE: begin
        if (!insn[F_ACC]) begin
          op             = OP_ROTATE;
          byte_op        = insn[F_WIDTH];
          dest.to_file   = insn[F_DSEL];
          dest.file_addr = insn[12:0];
          dest.reg_num   = 4'h0;
        end
      end
      OPC_STORE_T, OPC_STORE_R: begin
        op              = (insn[16]) ? OP_STORE_R : OP_STORE_T;
        dest.offset_reg = insn[14:11];
        shift_amt       = 6'($signed(insn[10:7]));
        dest.mode       = insn[6:4];
        dest.reg_num    = insn[3:0];
      end
      OPC_WIDEN: begin
        if (insn[15:11] == '0) begin
          op           = OP_WIDEN;
          dest.reg_num = insn[10:7];
          src.mode     = insn[6:4];
          src.reg_num  = insn[3:0];
        end
      end
      OPC_FILL_FILE: begin
        if (insn[F_ACC]) begin
          op             = OP_FILL;
          byte_op        = insn[F_WIDTH];
          dest.to_file   = insn[F_DSEL];
          dest.file_addr = insn[12:0];
          dest.reg_num   = 4'h0;
        end
      end
      OPC_FILL_REG: begin
        if (insn[F_ACC] && insn[6:0] == '0) begin
          op           = OP_FILL;
          byte_op      = insn[F_WIDTH];
          dest.mode    = insn[13:11];
          dest.reg_num = insn[10:7];
        end
      end
      OPC_ASHIFT: begin
        if (insn[14:8] == '0 && insn[7:6] == ASHIFT_TAG) begin
          op        = OP_ASHIFT;
          shift_amt = $signed(insn[5:0]);
        end
      end
      default: op = OP_NONE;
    endcase
    dest.byte_op = byte_op;
    dest.written = (op != OP_NONE) && (op != OP_ASHIFT);
  end

  // ==========================================================================
  // Accumulator shifter, shared by the store pre-shift and the literal shift
  logic [ACC_W-1:0] shift_in;
  logic [ACC_W-1:0] shift_out;
  logic             shift_ovf;
  logic             shift_clip;
  logic             clip_en;

  assign shift_in = acc_sel ? acc_b_q : acc_a_q;
  // Stores never clip the accumulator copy; only the written word is clipped
  assign clip_en  = (op == OP_ASHIFT) &&
                    (acc_sel ? ctrl_q[CTRL_B_CLIP] : ctrl_q[CTRL_A_CLIP]);

  rsase_acc_shift u_shift (
    .acc      (shift_in),
    .amount   (shift_amt),
    .clip_en  (clip_en),
    .result   (shift_out),
    .overflow (shift_ovf),
    .clipped  (shift_clip)
  );

  logic out_of_range;
  assign out_of_range = (op == OP_ASHIFT) && (shift_amt > SHIFT_MAX || shift_amt < SHIFT_MIN);

  // ==========================================================================
  // Store word: optional rounding, then optional write saturation
  function automatic logic [ACC_W-1:0] round_acc(input logic [ACC_W-1:0] v, input logic convergent);
    logic up;
    up = v[15];
    if (convergent && v[15:0] == 16'h8000) begin
      up = v[16];
    end
    round_acc = up ? v + ROUND_INC : v;
  endfunction

  logic [ACC_W-1:0]  store_acc;
  logic [WORD_W-1:0] store_word;

  always_comb begin
    if (op == OP_STORE_R) begin
      store_acc = round_acc(shift_out, ctrl_q[CTRL_ROUND_SEL]);
    end else begin
      store_acc = shift_out;
    end
    store_word = store_acc[31:16];
    if (ctrl_q[CTRL_WR_CLIP] &&
        !((store_acc[ACC_W-1:31] == '0) || (store_acc[ACC_W-1:31] == '1))) begin
      store_word = store_acc[ACC_W-1] ? WORD_NEG : WORD_POS;
    end
  end

  // ==========================================================================
  // Result word and N/Z for the register-file forms
  logic [WORD_W-1:0] res;
  logic              res_n;
  logic              res_z;

  always_comb begin
    case (op)
      OP_ROTATE: res = byte_op ? {8'h00, operand_q[0], operand_q[7:1]}
                               : {operand_q[0], operand_q[15:1]};
      OP_WIDEN:  res = {{8{operand_q[7]}}, operand_q[7:0]};
      OP_FILL:   res = byte_op ? FILL_BYTE : FILL_WORD;
      OP_STORE_T, OP_STORE_R: res = store_word;
      default:   res = result_q;
    endcase
    res_n = byte_op ? res[7] : res[15];
    res_z = byte_op ? (res[7:0] == '0) : (res == '0);
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && addr == ADDR_CTRL) begin
      ctrl_q <= pwdata[7:0] & CTRL_MASK;
    end
  end

  // ==========================================================================
  // Operand and instruction staging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_q <= '0;
      insn_q    <= '0;
    end else begin
      if (wr_en && addr == ADDR_OPERAND) begin
        operand_q <= pwdata[WORD_W-1:0];
      end
      if (exec) begin
        insn_q <= insn;
      end
    end
  end

  // ==========================================================================
  // Result and destination descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
      dest_q   <= '0;
      src_q    <= '0;
    end else if (exec) begin
      result_q <= res;
      dest_q   <= dest;
      src_q    <= src;
    end
  end

  // ==========================================================================
  // Accumulators
  logic acc_write;
  assign acc_write = exec && (op == OP_ASHIFT) && !out_of_range;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a_q <= '0;
      acc_b_q <= '0;
    end else if (acc_write) begin
      if (acc_sel) begin
        acc_b_q <= shift_out;
      end else begin
        acc_a_q <= shift_out;
      end
    end else if (wr_en) begin
      case (addr)
        ADDR_ACCA_LO: acc_a_q[31:0]  <= pwdata;
        ADDR_ACCA_HI: acc_a_q[39:32] <= pwdata[7:0];
        ADDR_ACCB_LO: acc_b_q[31:0]  <= pwdata;
        ADDR_ACCB_HI: acc_b_q[39:32] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Status flags
  logic [17:0] st_next;

  always_comb begin
    st_next = status_q;
    case (op)
      OP_ROTATE: begin
        st_next[ST_N] = res_n;
        st_next[ST_Z] = res_z;
      end
      OP_WIDEN: begin
        st_next[ST_N] = res_n;
        st_next[ST_Z] = res_z;
        st_next[ST_C] = !res_n;
      end
      OP_ASHIFT: begin
        if (out_of_range) begin
          st_next[ST_TRAP] = 1'b1;
        end else if (acc_sel) begin
          st_next[ST_OB] = shift_ovf;
          st_next[ST_SB] = status_q[ST_SB] | shift_clip;
        end else begin
          st_next[ST_OA] = shift_ovf;
          st_next[ST_SA] = status_q[ST_SA] | shift_clip;
        end
        st_next[ST_OAB] = st_next[ST_OA] | st_next[ST_OB];
        st_next[ST_SAB] = st_next[ST_SA] | st_next[ST_SB];
      end
      OP_NONE: st_next[ST_ILLEGAL] = 1'b1;
      default: st_next = status_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= ST_RESET;
    end else if (exec) begin
      status_q <= st_next;
    end else if (wr_en && addr == ADDR_STATUS) begin
      status_q <= pwdata[17:0];
    end
  end

  // ==========================================================================
  // Trap pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= exec && out_of_range;
    end
  end

  assign arith_trap = trap_q;

  // ==========================================================================
  // Read data, captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (addr)
        ADDR_CTRL:    prdata <= {24'h000000, ctrl_q};
        ADDR_STATUS:  prdata <= {14'h0000, status_q};
        ADDR_OPERAND: prdata <= {16'h0000, operand_q};
        ADDR_INSN:    prdata <= {8'h00, insn_q};
        ADDR_ACCA_LO: prdata <= acc_a_q[31:0];
        ADDR_ACCA_HI: prdata <= {24'h000000, acc_a_q[39:32]};
        ADDR_ACCB_LO: prdata <= acc_b_q[31:0];
        ADDR_ACCB_HI: prdata <= {24'h000000, acc_b_q[39:32]};
        ADDR_RESULT:  prdata <= {16'h0000, result_q};
        ADDR_DEST:    prdata <= {5'h00, dest_q};
        ADDR_SRC:     prdata <= {25'h0000000, src_q};
        default:      prdata <= '0;
      endcase
    end
  end

endmodule // rsase_core

// *** verif/rsase_core_assertions.sv ***
// Concurrent checks on the APB and trap ports of the execution block.
// Assumes it is bound to rsase_core and sees only that module's ports.
`timescale 1ns/1ns
module rsase_core_assertions import rsase_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              arith_trap
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Helper logic
  logic       acc_ph;
  logic       bad_exec;
  logic [7:0] ctrl_q;
  assign acc_ph   = psel && penable;
  assign bad_exec = acc_ph && pwrite && paddr[7:0] == ADDR_INSN && pwdata[23:16] == OPC_ASHIFT
                    && pwdata[7:6] == ASHIFT_TAG && pwdata[14:8] == 7'h00
                    && ($signed(pwdata[5:0]) > SHIFT_MAX || $signed(pwdata[5:0]) < SHIFT_MIN);

  // Shadow of the control register as software last wrote it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (acc_ph && pwrite && paddr[7:0] == ADDR_CTRL) begin
      ctrl_q <= pwdata[7:0] & CTRL_MASK;
    end
  end

  sequence trap_pulse_s;
    bad_exec ##1 arith_trap ##1 !arith_trap;
  endsequence

  // ==========================================================================
  // Properties
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("access phase not ready at once");
  trap_pulse_a: assert property (bad_exec |-> trap_pulse_s)
    else $error("out of range shift gave no single trap pulse");
  trap_cause_a: assert property ($rose(arith_trap) |-> $past(bad_exec))
    else $error("trap without an out of range shift");
  slverr_idle_a: assert property (!acc_ph |-> !pslverr)
    else $error("error flag outside access phase");
  slverr_unmapped_a: assert property (acc_ph && paddr[7:0] > 8'h28 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  slverr_mapped_a: assert property (acc_ph && paddr[7:0] <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  ctrl_read_a: assert property (acc_ph && !pwrite && paddr[7:0] == ADDR_CTRL |-> prdata == {24'h0, ctrl_q})
    else $error("control readback differs from last write");
  prdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read");
endmodule // rsase_core_assertions

// *** verif/rsase_host_model.sv ***
// Host side model: an APB master that software uses to reach the block.
// Assumes zero or more wait states; a stuck slave raises hung.
`timescale 1ns/1ns
module rsase_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             hung
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    hung    = 1'b0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 64) hung <= 1'b1;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // rsase_host_model

// *** verif/rsase_core_test.sv ***
// Self-checking testbench for the execution block, driven over APB.
// Assumes the host model above and the checker bound at the foot.
`timescale 1ns/1ns
module rsase_core_test;
  import rsase_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, arith_trap, hung;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          n_errors, n_compared;

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  rsase_core #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .arith_trap(arith_trap));
  rsase_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));

  // ==========================================================================
  // Shared tasks
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hung) begin
    n_errors++;
    wrap_up();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0, q, e);
    check(q & m, exp);
  endtask
  task automatic run(input logic [15:0] opnd, input logic [23:0] insn);
    wr(ADDR_OPERAND, {16'h0, opnd});
    wr(ADDR_INSN, {8'h0, insn});
  endtask
  task automatic set_acc(input logic [7:0] lo_a, input logic [31:0] lo, input logic [7:0] hi);
    wr(lo_a, lo);
    wr(lo_a + 8'h04, {24'h0, hi});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_bus;
    logic [31:0] q;
    logic        e;
    rd(ADDR_CTRL, 32'h0);
    host.xfer(1'b0, 8'h40, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    wr(ADDR_CTRL, 32'hffffffff);
    rd(ADDR_CTRL, 32'h000000e2);
    wr(ADDR_RESULT, 32'h1234);
    rd(ADDR_RESULT, 32'h0);
    $display("bus test done");
  endtask
  task automatic t_rotate;
    wr(ADDR_STATUS, 32'h1);
    run(16'h0001, {OPC_ROT_REG, 16'h0ab2});
    rd(ADDR_RESULT, 32'h8000);
    rd(ADDR_STATUS, 32'h9);
    rd(ADDR_DEST, 32'h04000015);
    rd(ADDR_SRC, 32'h32);
    run(16'hff01, {OPC_ROT_REG, 16'h4180});
    rd(ADDR_RESULT, 32'h0080);
    rd(ADDR_DEST, 32'h06000003);
    run(16'h0000, {OPC_ROT_REG, 16'h0ab2});
    rd(ADDR_STATUS, 32'h3);
    $display("rotate test done");
  endtask
  task automatic t_store;
    wr(ADDR_CTRL, 32'h20);
    wr(ADDR_STATUS, 32'h1);
    set_acc(ADDR_ACCA_LO, 32'h120fff00, 8'h00);
    run(16'h0, {OPC_STORE_T, 16'h3a05});
    rd(ADDR_RESULT, 32'h0120);
    rd(ADDR_DEST, 32'h04000385);
    run(16'h0, {OPC_STORE_R, 16'h3a05});
    rd(ADDR_RESULT, 32'h0121);
    rd(ADDR_ACCA_LO, 32'h120fff00);
    rd(ADDR_STATUS, 32'h1);
    set_acc(ADDR_ACCB_LO, 32'hc8918f4c, 8'hff);
    run(16'h0, {OPC_STORE_T, 16'h8600});
    rd(ADDR_RESULT, 32'h8000);
    wr(ADDR_CTRL, 32'h02);
    run(16'h0, {OPC_STORE_T, 16'h8600});
    rd(ADDR_RESULT, 32'h8918);
    set_acc(ADDR_ACCA_LO, 32'h00008000, 8'h00);
    run(16'h0, {OPC_STORE_R, 16'h0000});
    rd(ADDR_RESULT, 32'h0000);
    wr(ADDR_CTRL, 32'h00);
    run(16'h0, {OPC_STORE_R, 16'h0000});
    rd(ADDR_RESULT, 32'h0001);
    $display("store test done");
  endtask
  task automatic t_widen_fill;
    wr(ADDR_STATUS, 32'h0);
    run(16'h7839, {OPC_WIDEN, 16'h0200});
    rd(ADDR_RESULT, 32'h0039);
    rd(ADDR_STATUS, 32'h1);
    run(16'h008f, {OPC_WIDEN, 16'h0200});
    rd(ADDR_RESULT, 32'hff8f);
    rd(ADDR_STATUS, 32'h8);
    wr(ADDR_STATUS, 32'hb);
    run(16'h0, {OPC_FILL_FILE, 16'hc891});
    rd(ADDR_RESULT, 32'h00ff);
    rd(ADDR_DEST, 32'h06000000, 32'h0700000f);
    run(16'h0, {OPC_FILL_FILE, 16'hbfff});
    rd(ADDR_RESULT, 32'hffff);
    rd(ADDR_DEST, 32'h05fff800, 32'h07fff800);
    run(16'h0, {OPC_FILL_REG, 16'hd300});
    rd(ADDR_RESULT, 32'h00ff);
    rd(ADDR_STATUS, 32'hb);
    $display("widen and fill test done");
  endtask
  task automatic t_ashift;
    wr(ADDR_CTRL, 32'h80);
    wr(ADDR_STATUS, 32'h0);
    set_acc(ADDR_ACCA_LO, 32'h120fff00, 8'h00);
    run(16'h0, {OPC_ASHIFT, 16'h004c});
    rd(ADDR_ACCA_LO, 32'h000120ff);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h40);
    set_acc(ADDR_ACCB_LO, 32'hfff18f4c, 8'hff);
    run(16'h0, {OPC_ASHIFT, 16'h8076});
    rd(ADDR_ACCB_LO, 32'hc63d3000);
    run(16'h0, {OPC_ASHIFT, 16'h8050});
    rd(ADDR_ACCB_LO, 32'hffffc63d);
    rd(ADDR_ACCB_HI, 32'h000000ff);
    wr(ADDR_CTRL, 32'h00);
    set_acc(ADDR_ACCA_LO, 32'h320fab09, 8'h00);
    run(16'h0, {OPC_ASHIFT, 16'h007c});
    rd(ADDR_ACCA_HI, 32'h03);
    rd(ADDR_STATUS, 32'h8800);
    wr(ADDR_CTRL, 32'h80);
    set_acc(ADDR_ACCA_LO, 32'h320fab09, 8'h00);
    run(16'h0, {OPC_ASHIFT, 16'h007c});
    rd(ADDR_ACCA_LO, 32'h7fffffff);
    wr(ADDR_STATUS, 32'h0);
    run(16'h0, {OPC_ASHIFT, 16'h0051});
    #1;
    check({31'h0, arith_trap}, 32'h1);
    run(16'h0, {OPC_ASHIFT, 16'h006f});
    rd(ADDR_ACCA_LO, 32'h7fffffff);
    rd(ADDR_STATUS, 32'h10000, 32'h10000);
    $display("accumulator shift test done");
  endtask

  initial begin
    n_errors   = 0;
    n_compared = 0;
    presetn    = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_rotate();
    t_store();
    t_widen_fill();
    t_ashift();
    wrap_up();
  end
endmodule // rsase_core_test

bind rsase_core rsase_core_assertions #(.ADDR_W(ADDR_W)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .arith_trap(arith_trap));
